/* File: acc_pkg.sv */
// Shared constants and types for the converter control block
package acc_pkg;

  // Register byte offsets
  localparam logic [7:0] ACC_OFS_CTRL   = 8'h00;
  localparam logic [7:0] ACC_OFS_CLKSEL = 8'h04;
  localparam logic [7:0] ACC_OFS_PINCFG = 8'h08;
  localparam logic [7:0] ACC_OFS_RESL   = 8'h0c;
  localparam logic [7:0] ACC_OFS_RESH   = 8'h10;
  localparam logic [7:0] ACC_OFS_STAT   = 8'h14;
  localparam logic [7:0] ACC_OFS_MASK   = 8'h18;

  // Control register fields
  localparam int ACC_CTRL_START_BIT = 0;
  localparam int ACC_CTRL_BUSY_BIT  = 1;
  localparam int ACC_CTRL_CHAN_LSB  = 4;

  // Clock select register fields
  localparam int ACC_CLK_SEL_LSB  = 0;
  localparam int ACC_CLK_PDWN_BIT = 7;

  // Reset values
  localparam logic [2:0] ACC_CLK_SEL_RST = 3'h0;
  localparam logic       ACC_PDWN_RST    = 1'b1;
  localparam logic [7:0] ACC_PINSEL_RST  = 8'h00;

  // Converter
  localparam int         ACC_RES_BITS   = 12;
  localparam logic [4:0] ACC_CONV_TICKS = 5'h10;
  localparam int         ACC_DIV_BITS   = 5;

  // Clock select codes
  localparam logic [2:0] ACC_DIV2  = 3'h0;
  localparam logic [2:0] ACC_DIV8  = 3'h1;
  localparam logic [2:0] ACC_DIV32 = 3'h2;
  localparam logic [2:0] ACC_DIV1  = 3'h4;
  localparam logic [2:0] ACC_DIV4  = 3'h5;
  localparam logic [2:0] ACC_DIV16 = 3'h6;

  typedef enum logic [1:0] {ACC_IDLE, ACC_ARMED, ACC_CONV} acc_state_type;

  typedef struct packed {
    logic [7:0] pad_in;
    logic [7:0] gpio_oe;
    logic [7:0] gpio_out;
    logic [7:0] gpio_pullup;
  } acc_port_type;

endpackage

/* File: acc_clkdiv.sv */
// Converter clock tick generator
`timescale 1ns/10ps
module acc_clkdiv
  import acc_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  output logic            tick
);

  logic [ACC_DIV_BITS-1:0] cnt_r;
  logic [ACC_DIV_BITS-1:0] last;

  // One tick every divider period
  always_comb
  begin
    case (sel)
      ACC_DIV1:  last = 5'h00;
      ACC_DIV2:  last = 5'h01;
      ACC_DIV4:  last = 5'h03;
      ACC_DIV8:  last = 5'h07;
      ACC_DIV16: last = 5'h0f;
      ACC_DIV32: last = 5'h1f;
      // Undefined codes fall back to the slowest rate
      default:   last = 5'h1f;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= '0;
    else if (!run || cnt_r >= last)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + 5'h01;
  end

  assign tick = run && (cnt_r >= last);

endmodule

/* File: acc_sync.sv */
// Three-stage synchroniser with agreement filter
`timescale 1ns/10ps
module acc_sync
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic d,
  output logic      q
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q    <= 1'b0;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        q <= s3_r;
    end
  end

endmodule

/* File: acc_top.sv */
// Converter control block with APB registers
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
// Summary of operation
// - All select bits zero leaves pins GPIO
// - Power-down bit high stops converter
// - Result twelve bits, full scale FFF
// - Step equals supply divided by 4096
// - Half-step input offset in transfer
// - Start bit 0-1-0 resets then launches
// - Busy bit clears at conversion end
// - Result split into low/high bytes
// - Done flag sticky, interrupt when enabled
// - Conversion lasts sixteen converter clocks
// - Converter clock divides system clock
// - Three-bit select encodes six divider ratios
// - Power-down bit low enables converter
// - Selected pin is analog, pull-up off
module acc_top
  import acc_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire acc_port_type            port_in,
  input  wire logic [ACC_RES_BITS-1:0] sar_code,
  output logic      [7:0]              pad_analog_en,
  output logic      [7:0]              pad_oe,
  output logic      [7:0]              pad_out,
  output logic      [7:0]              pad_pullup,
  output logic      [7:0]              gpio_in,
  output logic      [2:0]              sar_chan,
  output logic                         sar_power_on,
  output logic                         sar_sample,
  output logic                         irq
);

  logic [2:0]              clk_sel_r;
  logic                    pdwn_r;
  logic [7:0]              pinsel_r;
  logic [2:0]              chan_r;
  logic                    start_r;
  logic                    busy_r;
  logic [ACC_RES_BITS-1:0] result_r;
  logic                    done_flag_r;
  logic                    done_mask_r;
  acc_state_type           state_r;
  logic [4:0]              tick_cnt_r;
  logic                    tick;
  logic                    conv_end;
  logic                    wr_en;
  logic                    rd_en;
  logic                    addr_ok;
  logic [7:0]              pad_sync;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign conv_end = (state_r == ACC_CONV) && tick && (tick_cnt_r == ACC_CONV_TICKS - 5'h01);

  always_comb
  begin
    case (paddr)
      ACC_OFS_CTRL, ACC_OFS_CLKSEL, ACC_OFS_PINCFG, ACC_OFS_RESL,
      ACC_OFS_RESH, ACC_OFS_STAT, ACC_OFS_MASK: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_sel_r <= ACC_CLK_SEL_RST;
      pdwn_r    <= ACC_PDWN_RST;
      pinsel_r  <= ACC_PINSEL_RST;
      chan_r    <= 3'h0;
      start_r   <= 1'b0;
      done_mask_r <= 1'b0;
    end
    else if (wr_en)
    begin
      case (paddr)
        ACC_OFS_CLKSEL:
        begin
          clk_sel_r <= pwdata[ACC_CLK_SEL_LSB +: 3];
          pdwn_r    <= pwdata[ACC_CLK_PDWN_BIT];
        end
        ACC_OFS_PINCFG: pinsel_r <= pwdata[7:0];
        ACC_OFS_CTRL:
        begin
          start_r <= pwdata[ACC_CTRL_START_BIT];
          chan_r  <= pwdata[ACC_CTRL_CHAN_LSB +: 3];
        end
        ACC_OFS_MASK: done_mask_r <= pwdata[0];
        default: ;
      endcase
    end
  end

  acc_clkdiv u_div
  (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (state_r == ACC_CONV),
    .sel     (clk_sel_r),
    .tick    (tick)
  );

  // Start sequencing: low resets, rise arms, fall launches
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r    <= ACC_IDLE;
      tick_cnt_r <= 5'h00;
      busy_r     <= 1'b0;
    end
    else if (pdwn_r)
    begin
      // Powered down converter cannot run
      state_r <= ACC_IDLE;
      busy_r  <= 1'b0;
    end
    else
    begin
      case (state_r)
        ACC_IDLE:
          if (start_r)
            state_r <= ACC_ARMED;
        ACC_ARMED:
          if (!start_r)
          begin
            state_r    <= ACC_CONV;
            tick_cnt_r <= 5'h00;
            busy_r     <= 1'b1;
          end
        ACC_CONV:
          if (start_r)
          begin
            // Raising start mid-conversion aborts and rearms
            state_r <= ACC_ARMED;
            busy_r  <= 1'b0;
          end
          else if (conv_end)
          begin
            state_r <= ACC_IDLE;
            busy_r  <= 1'b0;
          end
          else if (tick)
            tick_cnt_r <= tick_cnt_r + 5'h01;
        default: state_r <= ACC_IDLE;
      endcase
    end
  end

  // Result capture, code fixed by analog front end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result_r <= '0;
    else if (conv_end && !pdwn_r && !start_r)
      result_r <= sar_code;
  end

  // Sticky flag: set wins over write-one-clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_flag_r <= 1'b0;
    else if (conv_end && !pdwn_r && !start_r)
      done_flag_r <= 1'b1;
    else if (wr_en && paddr == ACC_OFS_STAT && pwdata[0])
      done_flag_r <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= done_flag_r && done_mask_r;
  end

  // APB read and answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          ACC_OFS_CTRL:   prdata <= {25'h0, chan_r, 2'h0, busy_r, start_r};
          ACC_OFS_CLKSEL: prdata <= {24'h0, pdwn_r, 4'h0, clk_sel_r};
          ACC_OFS_PINCFG: prdata <= {24'h0, pinsel_r};
          ACC_OFS_RESL:   prdata <= {24'h0, result_r[7:0]};
          ACC_OFS_RESH:   prdata <= {28'h0, result_r[11:8]};
          ACC_OFS_STAT:   prdata <= {31'h0, done_flag_r};
          ACC_OFS_MASK:   prdata <= {31'h0, done_mask_r};
          default:        prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pin
      acc_sync u_sync
      (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (port_in.pad_in[gi]),
        .q       (pad_sync[gi])
      );
    end
  endgenerate

  // Pin muxing: analog pins drop driver and pull-up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad_analog_en <= 8'h00;
      pad_oe        <= 8'h00;
      pad_out       <= 8'h00;
      pad_pullup    <= 8'h00;
      gpio_in       <= 8'h00;
    end
    else
    begin
      pad_analog_en <= pinsel_r;
      pad_oe        <= port_in.gpio_oe & ~pinsel_r;
      pad_out       <= port_in.gpio_out;
      pad_pullup    <= port_in.gpio_pullup & ~pinsel_r;
      gpio_in       <= pad_sync & ~pinsel_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sar_chan     <= 3'h0;
      sar_power_on <= 1'b0;
      sar_sample   <= 1'b0;
    end
    else
    begin
      sar_chan     <= chan_r;
      sar_power_on <= !pdwn_r;
      sar_sample   <= (state_r == ACC_CONV);
    end
  end

  // Cycle count of the running conversion; bit 9 marks a divider change
  logic [4:0] chk_div_last;
  logic [9:0] conv_cyc_r;
  always_comb
  begin
    case (clk_sel_r)
      ACC_DIV1:  chk_div_last = 5'h00;
      ACC_DIV2:  chk_div_last = 5'h01;
      ACC_DIV4:  chk_div_last = 5'h03;
      ACC_DIV8:  chk_div_last = 5'h07;
      ACC_DIV16: chk_div_last = 5'h0f;
      default:   chk_div_last = 5'h1f;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conv_cyc_r <= 10'h000;
    else if (state_r != ACC_CONV)
      conv_cyc_r <= 10'h000;
    else if (!$stable(clk_sel_r))
      conv_cyc_r <= 10'h200;
    else
      conv_cyc_r <= conv_cyc_r + 10'h001;
  end

  // Busy lasts exactly sixteen ticks unless aborted or powered down
  AST_BUSY_ON_LAUNCH: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ACC_ARMED && !start_r && !pdwn_r) |=> busy_r)
    else $error("busy not set on launch");
  AST_BUSY_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    conv_end && !pdwn_r && !start_r |=> !busy_r && done_flag_r)
    else $error("busy or flag wrong at end");
  AST_END_TICKS: assert property (@(posedge pclk) disable iff (!presetn)
    conv_end && !conv_cyc_r[9] |-> conv_cyc_r == {1'b0, chk_div_last, 4'hf})
    else $error("conversion not sixteen ticks");
  AST_DIV1_TICK: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ACC_CONV && clk_sel_r == ACC_DIV1) |-> tick)
    else $error("divide by one not ticking");
  AST_DIV2_TICK: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && clk_sel_r == ACC_DIV2 && $stable(clk_sel_r) && state_r == ACC_CONV)
      |=> !tick)
    else $error("divide by two ticks too often");
  AST_PDWN_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    pdwn_r |=> state_r == ACC_IDLE && !busy_r)
    else $error("converter active while powered down");
  AST_NO_ANALOG: assert property (@(posedge pclk) disable iff (!presetn)
    pinsel_r == 8'h00 |=> pad_analog_en == 8'h00)
    else $error("analog pin without select");
  AST_PULLUP_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> (pad_pullup & $past(pinsel_r)) == 8'h00)
    else $error("pull-up on analog pin");
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    done_flag_r && done_mask_r |=> irq)
    else $error("interrupt not raised");
  AST_RESULT: assert property (@(posedge pclk) disable iff (!presetn)
    conv_end && !pdwn_r && !start_r |=> result_r == $past(sar_code))
    else $error("result not captured");

  COV_CONV_DONE: cover property (@(posedge pclk) disable iff (!presetn) conv_end);
  COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  COV_ABORT: cover property (@(posedge pclk) disable iff (!presetn)
    state_r == ACC_CONV && start_r);

endmodule

/* File: acc_far_model.sv */
// Analog front end and port pin model at the far side of the converter control
`timescale 1ns/10ps
module acc_far_model
  import acc_pkg::*;
(
  input  wire logic [2:0]              sar_chan,
  input  wire logic                    sar_power_on,
  input  wire logic [14:0]             lvl [8],
  input  wire logic [7:0]              pins,
  input  wire logic [7:0]              oe,
  input  wire logic [7:0]              out,
  input  wire logic [7:0]              pu,
  output acc_port_type                 port_in,
  output logic      [ACC_RES_BITS-1:0] sar_code
);
  int code;

  // Levels in eighths of a step; half-step offset, clamp at top code
  always_comb
  begin
    code = (int'(lvl[sar_chan]) + 4) / 8;
    if (code > 4095)
      code = 4095;
  end

  // Powered-down front end gives no valid code
  assign sar_code = sar_power_on ? 12'(code) : ~12'(code);
  assign port_in  = {pins, oe, out, pu};
endmodule

/* File: testbench.sv */
// Self-checking bench for the converter control block
`timescale 1ns/10ps
module testbench
  import acc_pkg::*;
;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic         sar_power_on, sar_sample, irq;
  logic [7:0]   paddr, pins, g_oe, g_out, g_pu, sel;
  logic [7:0]   pad_analog_en, pad_oe, pad_out, pad_pullup, gpio_in;
  logic [31:0]  pwdata, prdata, rd;
  logic [11:0]  sar_code;
  logic [2:0]   sar_chan;
  logic [14:0]  lvl [8];
  acc_port_type port_in;
  int           mismatches, checked, hi_tot, base, m_mask;
  int           exp_q [$];
  int           dv [8] = '{2, 8, 32, 32, 1, 4, 16, 32};

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk)
    if (sar_sample === 1'b1)
      hi_tot <= hi_tot + 1;

  acc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_in(port_in), .sar_code(sar_code),
    .pad_analog_en(pad_analog_en), .pad_oe(pad_oe), .pad_out(pad_out),
    .pad_pullup(pad_pullup), .gpio_in(gpio_in), .sar_chan(sar_chan),
    .sar_power_on(sar_power_on), .sar_sample(sar_sample), .irq(irq));

  acc_far_model far (.sar_chan(sar_chan), .sar_power_on(sar_power_on), .lvl(lvl),
    .pins(pins), .oe(g_oe), .out(g_out), .pu(g_pu), .port_in(port_in),
    .sar_code(sar_code));

  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic fail_out();
    mismatches++;
    complete_run();
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      fail_out();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic launch(input int ch, input logic [2:0] cs);
    apb(1'b1, ACC_OFS_CLKSEL, {29'h0, cs});
    apb(1'b1, ACC_OFS_CTRL, 32'(ch << 4));
    apb(1'b1, ACC_OFS_CTRL, 32'(ch << 4) | 32'h1);
    base = hi_tot;
    apb(1'b1, ACC_OFS_CTRL, 32'(ch << 4));
  endtask

  task automatic fin(input int ch, input int d);
    int n, e;
    n = 0;
    e = (int'(lvl[ch]) + 4) / 8;
    if (e > 4095)
      e = 4095;
    exp_q.push_back(e);
    while ((sar_sample !== 1'b0 || hi_tot == base) && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000)
      fail_out();
    n = hi_tot - base;
    chk(32'(n), 32'(16 * d));
    repeat (2) @(posedge pclk);
    apb(1'b0, ACC_OFS_CTRL, 32'h0);
    chk(32'(rd[1]), 32'h0);
    e = exp_q.pop_front();
    apb(1'b0, ACC_OFS_RESL, 32'h0);
    chk(32'(rd[7:0]), 32'(e[7:0]));
    apb(1'b0, ACC_OFS_RESH, 32'h0);
    chk(32'(rd[3:0]), 32'(e[11:8]));
    apb(1'b0, ACC_OFS_STAT, 32'h0);
    chk(32'(rd[0]), 32'h1);
    chk(32'(irq), 32'(m_mask));
    apb(1'b1, ACC_OFS_STAT, 32'h1);
    apb(1'b0, ACC_OFS_STAT, 32'h0);
    chk(32'(rd[0]), 32'h0);
    chk(32'(irq), 32'h0);
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(32'h0627));
    foreach (lvl[i])
      lvl[i] = 15'($urandom);
    lvl[0] = 15'h0;
    lvl[7] = 15'h7fff;
    {pins, g_oe, g_out, g_pu} = $urandom;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'(sar_power_on), 32'h0);
    apb(1'b0, ACC_OFS_CLKSEL, 32'h0);
    chk(32'(rd[7:0]), 32'h80);
    apb(1'b0, ACC_OFS_PINCFG, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("test reset done");
    repeat (8) @(posedge pclk);
    chk({pad_analog_en, pad_oe, pad_pullup, gpio_in}, {8'h0, g_oe, g_pu, pins});
    sel = 8'($urandom);
    apb(1'b1, ACC_OFS_PINCFG, {24'h0, sel});
    repeat (8) @(posedge pclk);
    chk({pad_analog_en, pad_oe, pad_pullup, gpio_in},
        {sel, g_oe & ~sel, g_pu & ~sel, pins & ~sel});
    chk(32'(pad_out), 32'(g_out));
    $display("test pins done");
    for (int i = 0; i < 8; i++)
    begin
      m_mask = i % 2;
      apb(1'b1, ACC_OFS_MASK, 32'(m_mask));
      launch(i, 3'(i));
      chk(32'(sar_power_on), 32'h1);
      apb(1'b0, ACC_OFS_CTRL, 32'h0);
      chk({rd[6:4], rd[1:0], sar_chan}, {3'(i), 2'b10, 3'(i)});
      fin(i, dv[i]);
    end
    $display("test conversions done");
    launch(3, ACC_DIV32);
    repeat (40) @(posedge pclk);
    chk(32'(sar_sample), 32'h1);
    apb(1'b1, ACC_OFS_CTRL, 32'h31);
    repeat (3) @(posedge pclk);
    chk(32'(sar_sample), 32'h0);
    base = hi_tot;
    apb(1'b1, ACC_OFS_CTRL, 32'h30);
    fin(3, 32);
    $display("test abort done");
    launch(5, ACC_DIV32);
    apb(1'b1, ACC_OFS_CLKSEL, 32'h82);
    repeat (3) @(posedge pclk);
    chk({sar_power_on, sar_sample}, 2'b00);
    launch(5, ACC_DIV32 | 3'h0);
    apb(1'b1, ACC_OFS_CLKSEL, 32'h82);
    repeat (3) @(posedge pclk);
    chk(32'(sar_sample), 32'h0);
    apb(1'b0, ACC_OFS_STAT, 32'h0);
    chk(32'(rd[0]), 32'h0);
    apb(1'b1, ACC_OFS_CLKSEL, 32'h80);
    $display("test power done");
    complete_run();
  end
endmodule
